//--- logic/nbf_pkg.sv
// ninth-bit flag tracking: shared constants, opcode enum and carrier structs
// assumes the instruction decoder delivers one decoded request per cycle
package nbf_pkg;

  // position of the ninth bit inside a 9-bit location value
  localparam int NBF_NINTH = 8;
  // status-word bit that carries the flag when the status word is popped
  localparam int NBF_PSW_FLAG_BIT = 1;
  // longest wait sequence, in clock cycles
  localparam logic [1:0] NBF_WAIT_MAX = 2'h2;
  // width of the lost-cycle counter
  localparam int NBF_LAG_W = 16;
  // reset values
  localparam logic NBF_FLAG_RST = 1'b0;
  localparam logic [8:0] NBF_LOC_RST = 9'h000;

  // decoded instruction classes that touch the flag or the ninth bits
  typedef enum logic [4:0] {
    NBF_OP_NONE = 5'h00, // bit ops, branches, other: nothing changes
    NBF_OP_LDI = 5'h01, // immediate load: nothing changes
    NBF_OP_LD = 5'h02,
    NBF_OP_LDW = 5'h03,
    NBF_OP_ST = 5'h04,
    NBF_OP_STW = 5'h05,
    NBF_OP_MOV = 5'h06,
    NBF_OP_PUSHI = 5'h07,
    NBF_OP_PUSH = 5'h08,
    NBF_OP_PUSHW = 5'h09,
    NBF_OP_PUSH_F = 5'h0A,
    NBF_OP_PUSH_BA = 5'h0B,
    NBF_OP_POP = 5'h0C,
    NBF_OP_POPW = 5'h0D,
    NBF_OP_POP_F = 5'h0E,
    NBF_OP_POP_BA = 5'h0F,
    NBF_OP_XCH = 5'h10,
    NBF_OP_WORD_EXCHANGE = 5'h11,
    NBF_OP_INC = 5'h12,
    NBF_OP_WORD_INCREMENT = 5'h13,
    NBF_OP_DEC = 5'h14,
    NBF_OP_WORD_DECREMENT = 5'h15,
    NBF_OP_DEC_BRANCH_IF_NONZERO = 5'h16,
    NBF_OP_DEC_BRANCH_IF_ZERO = 5'h17,
    NBF_OP_MULDIV_24BIT = 5'h18
  } nbf_op_t;

  // decoded request from the instruction decoder
  typedef struct packed {
    logic valid; // one instruction offered
    nbf_op_t op; // instruction class
    logic psw_dst; // pop target is the program status word
    logic lo_has9; // low operand location has a ninth bit
    logic hi_has9; // high operand location has a ninth bit
    logic [8:0] lo; // low operand, ninth bit on top
    logic [8:0] hi; // high operand, ninth bit on top
  } nbf_req_t;

  // write-back toward the register file / ram
  typedef struct packed {
    logic valid; // one-cycle result strobe
    logic wr_lo; // write lo to destination low location
    logic wr_hi; // write hi to destination high location
    logic [8:0] lo; // low value, ninth bit on top
    logic [8:0] hi; // high value, ninth bit on top
    logic branch; // decrement-and-branch condition met
  } nbf_res_t;

endpackage : nbf_pkg

//--- logic/nbf_step.sv
// ninth-bit flag tracking: 9-bit / 17-bit increment and decrement unit
// purely combinational; the caller registers its outputs
`timescale 1ns/10ps
`default_nettype none
module nbf_step (
  input wire logic dec,
  input wire logic word,
  input wire logic [8:0] lo_in,
  input wire logic [8:0] hi_in,
  output logic [8:0] lo_out,
  output logic [8:0] hi_out
);
  import nbf_pkg::*;

  logic [8:0] lo8_sum; // low byte with carry or borrow on top
  logic [8:0] hi_sum; // high 9 bits after propagation

  // byte forms count over all 9 bits; word forms over 8+9 bits
  always_comb begin
    lo8_sum = 9'h000;
    hi_sum = hi_in;
    if (!word) begin
      lo_out = dec ? (lo_in - 9'h001) : (lo_in + 9'h001);
      hi_out = hi_in;
    end else begin
      // low byte only; its carry goes into the low ninth bit
      lo8_sum = dec ? ({1'b0, lo_in[7:0]} - 9'h001) : ({1'b0, lo_in[7:0]} + 9'h001);
      if (dec) begin
        hi_sum = hi_in - {8'h00, lo8_sum[NBF_NINTH]};
        lo_out = {~lo8_sum[NBF_NINTH], lo8_sum[7:0]};
      end else begin
        hi_sum = hi_in + {8'h00, lo8_sum[NBF_NINTH]};
        lo_out = lo8_sum;
      end
      hi_out = hi_sum;
    end
  end

endmodule : nbf_step
`default_nettype wire

//--- logic/nbf_core.sv
// ninth-bit flag tracking: flag register, ninth-bit write-back and wait stall
// assumes decoded requests and a wait request from the core, one clock domain
//
// Operation
// - no wait is ever generated internally
// - wait request stalls execution for its first two cycles
// - peripherals keep running during a wait
// - a wait lasts at most two cycles
// - no wait in halt or hold standby
// - program steps lag time after a wait
// - loads copy ninth bit; stores write flag
// - status word pop takes flag from bit1
// - increment over 9/17 bits, flag after
// - decrement over 9/17 bits, branch on low byte
// - 24-bit multiply/divide results get ninth bit one
// - plain byte register reads ninth bit as one
`timescale 1ns/10ps
`default_nettype none
module nbf_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire nbf_pkg::nbf_req_t req,
  input wire logic wait_req,
  input wire logic halt_mode,
  input wire logic hold_mode,
  output logic req_ready,
  output logic core_stall,
  output logic periph_run,
  output nbf_pkg::nbf_res_t res,
  output logic ninth_bit_flag,
  output logic pc_step,
  output logic [nbf_pkg::NBF_LAG_W-1:0] lag_cycles
);
  import nbf_pkg::*;

  // all state of the block
  typedef struct packed {
    logic flag; // ninth-bit flag of the status word
    nbf_res_t res; // registered write-back
    logic [1:0] wait_cnt; // cycles spent in the current wait
    logic step; // instruction retired this cycle
    logic [NBF_LAG_W-1:0] lag; // wait cycles seen so far
  } nbf_state_t;

  nbf_state_t st_q; // registered state
  nbf_state_t st_d; // next state

  logic take; // request accepted this cycle
  logic lo9; // low ninth bit as read
  logic hi9; // high ninth bit as read
  logic [8:0] step_lo; // inc/dec unit low result
  logic [8:0] step_hi; // inc/dec unit high result
  logic step_dec; // unit decrements
  logic step_word; // unit works on a word

  // ninth bit as read: a location without one reads as one
  function automatic logic read_ninth(input logic has9, input logic [8:0] v);
    read_ninth = has9 ? v[NBF_NINTH] : 1'b1;
  endfunction : read_ninth

  // value with the given ninth bit over the low byte
  function automatic logic [8:0] with_ninth(input logic n, input logic [8:0] v);
    with_ninth = {n, v[7:0]};
  endfunction : with_ninth

  // stall only on an outside request, never in standby, capped in length
  assign core_stall = wait_req && !halt_mode && !hold_mode && (st_q.wait_cnt < NBF_WAIT_MAX);
  assign req_ready = !core_stall;
  // peripherals are not gated by the stall
  assign periph_run = 1'b1;
  assign take = req.valid && !core_stall;

  assign lo9 = read_ninth(req.lo_has9, req.lo);
  assign hi9 = read_ninth(req.hi_has9, req.hi);

  // increment / decrement unit selection
  always_comb begin
    step_dec = 1'b0;
    step_word = 1'b0;
    unique case (req.op)
      NBF_OP_DEC, NBF_OP_DEC_BRANCH_IF_NONZERO, NBF_OP_DEC_BRANCH_IF_ZERO: begin
        step_dec = 1'b1;
      end
      NBF_OP_WORD_DECREMENT: begin
        step_dec = 1'b1;
        step_word = 1'b1;
      end
      NBF_OP_WORD_INCREMENT: begin
        step_word = 1'b1;
      end
      default: begin
        step_dec = 1'b0;
      end
    endcase
  end

  nbf_step u_step (
    .dec(step_dec),
    .word(step_word),
    .lo_in(with_ninth(lo9, req.lo)),
    .hi_in(with_ninth(hi9, req.hi)),
    .lo_out(step_lo),
    .hi_out(step_hi)
  );

  // next-state logic
  always_comb begin
    st_d = st_q;
    st_d.res.valid = 1'b0;
    st_d.res.wr_lo = 1'b0;
    st_d.res.wr_hi = 1'b0;
    st_d.res.branch = 1'b0;
    st_d.step = take;
    // wait length counter: counts stalled cycles, clears once the request goes
    if (core_stall) begin
      st_d.wait_cnt = st_q.wait_cnt + 2'h1;
      st_d.lag = st_q.lag + {{(NBF_LAG_W-1){1'b0}}, 1'b1};
    end else if (!wait_req) begin
      st_d.wait_cnt = 2'h0;
    end
    if (take) begin
      st_d.res.valid = 1'b1;
      st_d.res.lo = with_ninth(lo9, req.lo);
      st_d.res.hi = with_ninth(hi9, req.hi);
      unique case (req.op)
        // loads copy the source ninth bit into the flag
        NBF_OP_LD: st_d.flag = lo9;
        NBF_OP_LDW: st_d.flag = hi9;
        // stores and moves write the flag into the destination
        NBF_OP_ST, NBF_OP_MOV, NBF_OP_PUSHI, NBF_OP_PUSH_F: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.lo = with_ninth(st_q.flag, req.lo);
        end
        NBF_OP_STW, NBF_OP_PUSH_BA: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.res.lo = with_ninth(st_q.flag, req.lo);
          st_d.res.hi = with_ninth(st_q.flag, req.hi);
        end
        // push copies the location and loads the flag from it
        NBF_OP_PUSH: begin
          st_d.res.wr_lo = 1'b1;
          st_d.flag = lo9;
        end
        NBF_OP_PUSHW: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.flag = hi9;
        end
        // pops: status word target takes the flag from its bit 1
        NBF_OP_POP: begin
          st_d.res.wr_lo = 1'b1;
          st_d.flag = req.psw_dst ? req.lo[NBF_PSW_FLAG_BIT] : lo9;
        end
        NBF_OP_POPW: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.flag = req.psw_dst ? req.hi[NBF_PSW_FLAG_BIT] : hi9;
        end
        NBF_OP_POP_F: st_d.flag = req.lo[NBF_PSW_FLAG_BIT];
        NBF_OP_POP_BA: st_d.flag = hi9;
        // exchanges
        NBF_OP_XCH: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.lo = with_ninth(st_q.flag, req.lo);
          st_d.flag = lo9;
        end
        NBF_OP_WORD_EXCHANGE: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.res.lo = with_ninth(st_q.flag, req.lo);
          st_d.res.hi = with_ninth(st_q.flag, req.hi);
          st_d.flag = hi9;
        end
        // byte and word increment / decrement, flag from the result
        NBF_OP_INC, NBF_OP_DEC: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.lo = step_lo;
          st_d.flag = step_lo[NBF_NINTH];
        end
        NBF_OP_WORD_INCREMENT, NBF_OP_WORD_DECREMENT: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.res.lo = step_lo;
          st_d.res.hi = step_hi;
          st_d.flag = step_hi[NBF_NINTH];
        end
        // decrement and branch: condition sees the low 8 bits only
        NBF_OP_DEC_BRANCH_IF_NONZERO: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.lo = step_lo;
          st_d.flag = step_lo[NBF_NINTH];
          st_d.res.branch = (step_lo[7:0] != 8'h00);
        end
        NBF_OP_DEC_BRANCH_IF_ZERO: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.lo = step_lo;
          st_d.flag = step_lo[NBF_NINTH];
          st_d.res.branch = (step_lo[7:0] == 8'h00);
        end
        // multiply/divide results get their ninth bits set
        NBF_OP_MULDIV_24BIT: begin
          st_d.res.wr_lo = 1'b1;
          st_d.res.wr_hi = 1'b1;
          st_d.res.lo = with_ninth(1'b1, req.lo);
          st_d.res.hi = with_ninth(1'b1, req.hi);
        end
        // immediate loads, bit ops, branches: untouched
        NBF_OP_NONE, NBF_OP_LDI: begin
          st_d.flag = st_q.flag;
        end
        default: begin
          st_d.flag = st_q.flag;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q.flag <= NBF_FLAG_RST;
      st_q.res <= '0;
      st_q.wait_cnt <= 2'h0;
      st_q.step <= 1'b0;
      st_q.lag <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign res = st_q.res;
  assign ninth_bit_flag = st_q.flag;
  assign pc_step = st_q.step;
  assign lag_cycles = st_q.lag;

endmodule : nbf_core
`default_nettype wire

//--- verification/nbf_core_sva.sv
// ninth-bit flag tracking: port-level checker for nbf_core
// assumes one clock sys_clk and an async active-high rst
`timescale 1ns/10ps
`default_nettype none
module nbf_core_chk
  import nbf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire nbf_pkg::nbf_req_t req,
  input wire logic wait_req,
  input wire logic halt_mode,
  input wire logic hold_mode,
  input wire logic req_ready,
  input wire logic core_stall,
  input wire logic periph_run,
  input wire nbf_pkg::nbf_res_t res,
  input wire logic ninth_bit_flag,
  input wire logic pc_step,
  input wire logic [nbf_pkg::NBF_LAG_W-1:0] lag_cycles
);
  // request accepted at this edge
  wire logic take = req.valid && !core_stall;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_NO_SELF_WAIT: assert property (!wait_req |-> !core_stall)
    else $error("stall without wait request");
  AST_WAIT_STALLS: assert property ($rose(wait_req) && !halt_mode && !hold_mode
    |-> core_stall && !req_ready)
    else $error("wait request did not stall");
  AST_PERIPH_RUN: assert property (periph_run)
    else $error("peripherals gated");
  AST_WAIT_CAP: assert property (core_stall [*2] |=> !core_stall)
    else $error("stall longer than two cycles");
  AST_STANDBY: assert property (halt_mode || hold_mode |-> !core_stall)
    else $error("stall in standby");
  AST_LAG: assert property (core_stall |=> lag_cycles == $past(lag_cycles) + 1'b1)
    else $error("lag count not advanced");
  AST_LOAD_FLAG: assert property (take && req.op == NBF_OP_LD |=>
    ninth_bit_flag == ($past(req.lo[8]) | !$past(req.lo_has9)))
    else $error("load flag wrong");
  AST_STORE: assert property (take && req.op == NBF_OP_ST |=>
    res.wr_lo && res.lo[8] == $past(ninth_bit_flag))
    else $error("store ninth bit wrong");
  AST_POP_PSW: assert property (take && req.op == NBF_OP_POP_F |=>
    ninth_bit_flag == $past(req.lo[1]))
    else $error("status pop flag wrong");
  AST_MULDIV: assert property (take && req.op == NBF_OP_MULDIV_24BIT |=> res.lo[8])
    else $error("multiply result ninth bit clear");
endmodule : nbf_core_chk
`default_nettype wire

//--- verification/nbf_core_tb.sv
// ninth-bit flag tracking: self-checking bench for nbf_core
// assumes the package only; all inputs are driven at the falling edge
`timescale 1ns/10ps
`default_nettype none
module nbf_core_tb;
  import nbf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wait_req = 1'b0;
  logic halt_mode = 1'b0;
  logic hold_mode = 1'b0;
  nbf_req_t req = '0;
  logic req_ready, core_stall, periph_run, ninth_bit_flag, pc_step;
  nbf_res_t res;
  logic [NBF_LAG_W-1:0] lag_cycles;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  nbf_core dut (.sys_clk(sys_clk), .rst(rst), .req(req), .wait_req(wait_req),
    .halt_mode(halt_mode), .hold_mode(hold_mode), .req_ready(req_ready),
    .core_stall(core_stall), .periph_run(periph_run), .res(res),
    .ninth_bit_flag(ninth_bit_flag), .pc_step(pc_step), .lag_cycles(lag_cycles));

  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("counts: %0d mismatches, %0d comparisons", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one request for one cycle; returns where its results are visible
  task automatic issue(input nbf_op_t op, input logic [8:0] lo, input logic [8:0] hi = 9'h000,
                       input logic h9 = 1'b1, input logic ps = 1'b0);
    @(negedge sys_clk);
    req = '{1'b1, op, ps, h9, h9, lo, hi};
    @(negedge sys_clk);
    req.valid = 1'b0;
  endtask : issue

  task automatic t_move;
    issue(NBF_OP_LD, 9'h105);
    chk({res.valid, res.wr_lo, pc_step, ninth_bit_flag}, 4'hB);
    issue(NBF_OP_LDI, 9'h000);
    chk(ninth_bit_flag, 1'b1);
    issue(NBF_OP_ST, 9'h033);
    chk({res.wr_lo, res.lo}, 10'h333);
    issue(NBF_OP_LD, 9'h033);
    chk(ninth_bit_flag, 1'b0);
    issue(NBF_OP_LD, 9'h0AA, 9'h000, 1'b0);
    chk(ninth_bit_flag, 1'b1);
    issue(NBF_OP_MOV, 9'h044);
    chk(res.lo, 9'h144);
  endtask : t_move

  task automatic t_pop;
    issue(NBF_OP_POP_F, 9'h1FD);
    chk(ninth_bit_flag, 1'b0);
    issue(NBF_OP_POP, 9'h002, 9'h000, 1'b1, 1'b1);
    chk(ninth_bit_flag, 1'b1);
  endtask : t_pop

  // push, pop and word transfers of the flag and ninth bits
  task automatic t_stack;
    issue(NBF_OP_PUSHI, 9'h022);
    chk({res.wr_hi, res.wr_lo, res.lo}, 11'h322);
    issue(NBF_OP_PUSH, 9'h0AB);
    chk({ninth_bit_flag, res.wr_lo, res.lo}, 11'h2AB);
    issue(NBF_OP_PUSH_F, 9'h155);
    chk({res.wr_lo, res.lo}, 10'h255);
    issue(NBF_OP_PUSHW, 9'h011, 9'h1CC);
    chk({ninth_bit_flag, res.wr_hi, res.wr_lo}, 3'h7);
    chk({res.hi, res.lo}, {9'h1CC, 9'h011});
    issue(NBF_OP_STW, 9'h000, 9'h0FF);
    chk({res.hi, res.lo}, {9'h1FF, 9'h100});
    issue(NBF_OP_LDW, 9'h1AA, 9'h055);
    chk({ninth_bit_flag, res.wr_hi, res.wr_lo}, 3'h0);
    issue(NBF_OP_PUSH_BA, 9'h133, 9'h144);
    chk({res.hi[8], res.lo[8], res.wr_hi}, 3'h1);
    issue(NBF_OP_POPW, 9'h100, 9'h002, 1'b1, 1'b1);
    chk(ninth_bit_flag, 1'b1);
    issue(NBF_OP_POP_BA, 9'h1FF, 9'h0FF);
    chk({ninth_bit_flag, res.wr_hi, res.wr_lo}, 3'h0);
    issue(NBF_OP_NONE, 9'h1FF);
    chk({ninth_bit_flag, res.valid}, 2'h1);
  endtask : t_stack

  task automatic t_arith;
    issue(NBF_OP_INC, 9'h0FF);
    chk({ninth_bit_flag, res.lo}, 10'h300);
    issue(NBF_OP_INC, 9'h1FF);
    chk({ninth_bit_flag, res.lo}, 10'h000);
    issue(NBF_OP_DEC, 9'h000);
    chk({ninth_bit_flag, res.lo}, 10'h3FF);
    issue(NBF_OP_WORD_INCREMENT, 9'h0FF, 9'h012);
    chk({res.hi, res.lo}, 18'h02700);
    chk(ninth_bit_flag, 1'b0);
    issue(NBF_OP_WORD_DECREMENT, 9'h000, 9'h000);
    chk({res.hi, res.lo}, 18'h3FEFF);
    chk(ninth_bit_flag, 1'b1);
    issue(NBF_OP_DEC_BRANCH_IF_NONZERO, 9'h101);
    chk({res.branch, res.lo}, 10'h100);
    issue(NBF_OP_DEC_BRANCH_IF_ZERO, 9'h101);
    chk({res.branch, res.lo}, 10'h300);
  endtask : t_arith

  task automatic t_xch;
    issue(NBF_OP_XCH, 9'h055);
    chk({ninth_bit_flag, res.lo}, 10'h155);
    issue(NBF_OP_WORD_EXCHANGE, 9'h111, 9'h122);
    chk({res.hi[8], res.lo[8], ninth_bit_flag}, 3'h1);
    issue(NBF_OP_MULDIV_24BIT, 9'h012);
    chk({res.hi[8], res.lo[8]}, 2'h3);
  endtask : t_xch

  // stall capped at two cycles, lag counted, standby ignores the request
  task automatic t_wait;
    logic [15:0] l0;
    @(negedge sys_clk);
    l0 = lag_cycles;
    req = '{1'b1, NBF_OP_LD, 1'b0, 1'b1, 1'b1, 9'h033, 9'h000};
    wait_req = 1'b1;
    #1 chk({core_stall, req_ready}, 2'h2);
    @(negedge sys_clk);
    chk({core_stall, lag_cycles}, {1'b1, l0 + 16'h1});
    chk(periph_run, 1'b1);
    @(negedge sys_clk);
    chk({core_stall, lag_cycles}, {1'b0, l0 + 16'h2});
    @(negedge sys_clk);
    req.valid = 1'b0;
    wait_req = 1'b0;
    chk({pc_step, ninth_bit_flag}, 2'h2);
    @(negedge sys_clk);
    halt_mode = 1'b1;
    wait_req = 1'b1;
    #1 chk(core_stall, 1'b0);
    @(negedge sys_clk);
    halt_mode = 1'b0;
    hold_mode = 1'b1;
    #1 chk(core_stall, 1'b0);
    @(negedge sys_clk);
    hold_mode = 1'b0;
    wait_req = 1'b0;
  endtask : t_wait

  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk({ninth_bit_flag, lag_cycles}, 17'h0);
    t_move();
    t_pop();
    t_stack();
    t_arith();
    t_xch();
    t_wait();
    close_out();
  end
endmodule : nbf_core_tb

bind nbf_core nbf_core_chk chk_i (.sys_clk(sys_clk), .rst(rst), .req(req),
  .wait_req(wait_req), .halt_mode(halt_mode), .hold_mode(hold_mode),
  .req_ready(req_ready), .core_stall(core_stall), .periph_run(periph_run),
  .res(res), .ninth_bit_flag(ninth_bit_flag), .pc_step(pc_step),
  .lag_cycles(lag_cycles));
`default_nettype wire
